// >>> hdl/rdtpc_ctrl.sv
// drive strength, input termination and power-saving control word decode
// assumes word writes come from logic on clk; mirror, chip selects, clock
// enables and odt come from pins and are synchronised here
//
// Summary of operation
// - mirror high switches termination off except chip selects and odt
// - pre-launch selects early launch of command/address versus clocks and control
// - three independent drive groups: command/address, control, clock pairs
// - ca word bits 1:0 side A, 3:2 side B; light moderate strong reserved
// - control word bits 1:0 side A, 3:2 side B; light moderate, rest reserved
// - clock word bits 1:0 pairs 1 and 3, bits 3:2 pairs 0 and 2
// - extra termination bit 3 keeps termination on under mirror when set with code 000
// - termination code: 000 defer, 010 200 ohm, 100 300 ohm, 111 off
// - any nonzero termination code forces termination off under mirror
// - code 111 turns all termination off, chip select and odt included
// - with floating enabled, power bit 0 picks float or weak idle drive
// - weak drive applies to command/address outputs while all chip selects high
// - power bit 3 enables clock-enable power-down, default off; type ignored when off
// - power-down entered when both clock enable inputs are low
// - power bit 2: 0 keeps termination and odt follows, 1 off and odt low
// - timing bit 2 picks 100 or 150 ohm base termination, 100 at reset
// - floating puts command/address outputs high impedance when not driven
`timescale 1ns/1ns
module rdtpc_ctrl
  import rdtpc_pkg::*;
#(
  parameter int NUM_CS = 4
) (
  input  wire logic              clk,
  input  wire logic              nrst,
  input  wire rdtpc_write_s      word_write,
  input  wire logic              mirror_in,
  input  wire logic [NUM_CS-1:0] chip_select_in_n,
  input  wire logic              clock_enable_in0,
  input  wire logic              clock_enable_in1,
  input  wire logic              odt_input_pin,
  output rdtpc_drive_s           drive,
  output rdtpc_term_e            term_value,
  output logic                   term_on_main,
  output logic                   term_on_cs_odt,
  output logic                   ca_prelaunch,
  output rdtpc_idle_e            ca_idle_mode,
  output logic                   ca_float,
  output logic                   ca_weak,
  output logic                   power_down,
  output logic                   odt_out
);

  localparam int SYNC_W = NUM_CS + 4;

  // control words
  logic [3:0] global_features_word;
  logic [3:0] timing_word;
  logic [3:0] ca_drive_strength_word;
  logic [3:0] control_drive_strength_word;
  logic [3:0] clock_drive_strength_word;
  logic [3:0] extra_termination_word;
  logic [3:0] power_saving_word;

  // synchronised pins
  logic [SYNC_W-1:0] pins_raw;
  logic [SYNC_W-1:0] pins_sync;
  logic              mirror_s;
  logic [NUM_CS-1:0] cs_s;
  logic              cke0_s;
  logic              cke1_s;
  logic              odt_s;

  // decoded next values
  logic              all_deselected;
  logic [2:0]        term_code;
  logic              mirror_kills;
  logic              pd_active;
  rdtpc_term_e       next_term_value;
  logic              next_term_main;
  logic              next_term_cs_odt;
  rdtpc_idle_e       next_idle;

  // per-word write strobes
  logic              wr_global;
  logic              wr_timing;
  logic              wr_ca_drv;
  logic              wr_ctl_drv;
  logic              wr_clk_drv;
  logic              wr_ext_term;
  logic              wr_pwr_save;

  initial begin
    if (NUM_CS != 2 && NUM_CS != 4) $error("rdtpc_ctrl: chip selects must be 2 or 4");
  end

  assign pins_raw = {mirror_in, chip_select_in_n, clock_enable_in0,
                     clock_enable_in1, odt_input_pin};

  rdtpc_sync #(
    .WIDTH (SYNC_W)
  ) rdtpc_sync_i (
    .clk   (clk),
    .nrst  (nrst),
    .pin   (pins_raw),
    .level (pins_sync)
  );

  assign mirror_s = pins_sync[SYNC_W-1];
  assign cs_s     = pins_sync[NUM_CS+2:3];
  assign cke0_s   = pins_sync[2];
  assign cke1_s   = pins_sync[1];
  assign odt_s    = pins_sync[0];

  // one strobe per word; indices of other blocks match none and are dropped
  assign wr_global   = word_write.valid && (word_write.index == RDTPC_IDX_GLOBAL);
  assign wr_timing   = word_write.valid && (word_write.index == RDTPC_IDX_TIMING);
  assign wr_ca_drv   = word_write.valid && (word_write.index == RDTPC_IDX_CA_DRV);
  assign wr_ctl_drv  = word_write.valid && (word_write.index == RDTPC_IDX_CTL_DRV);
  assign wr_clk_drv  = word_write.valid && (word_write.index == RDTPC_IDX_CLK_DRV);
  assign wr_ext_term = word_write.valid && (word_write.index == RDTPC_IDX_EXT_TERM);
  assign wr_pwr_save = word_write.valid && (word_write.index == RDTPC_IDX_PWR_SAVE);

  // global features word; only the float enable is used here
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      global_features_word <= RDTPC_RST_WORD;
    end else if (wr_global) begin
      global_features_word <= word_write.nibble;
    end
  end

  // timing word; reset gives the 100 ohm base termination
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      timing_word <= RDTPC_RST_WORD;
    end else if (wr_timing) begin
      timing_word <= word_write.nibble;
    end
  end

  // command/address drive word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ca_drive_strength_word <= RDTPC_RST_WORD;
    end else if (wr_ca_drv) begin
      ca_drive_strength_word <= word_write.nibble;
    end
  end

  // control group drive word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      control_drive_strength_word <= RDTPC_RST_WORD;
    end else if (wr_ctl_drv) begin
      control_drive_strength_word <= word_write.nibble;
    end
  end

  // clock pair drive word
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      clock_drive_strength_word <= RDTPC_RST_WORD;
    end else if (wr_clk_drv) begin
      clock_drive_strength_word <= word_write.nibble;
    end
  end

  // extra termination word; mirror mode bit and termination code
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      extra_termination_word <= RDTPC_RST_WORD;
    end else if (wr_ext_term) begin
      extra_termination_word <= word_write.nibble;
    end
  end

  // power-saving word; reset leaves power-down disabled
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      power_saving_word <= RDTPC_RST_WORD;
    end else if (wr_pwr_save) begin
      power_saving_word <= word_write.nibble;
    end
  end

  // drive decode, one field per group and side; reserved codes pass through
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drive <= '{default: RDTPC_DRV_LIGHT};
    end else begin
      drive.ca_a   <= rdtpc_drive_e'(ca_drive_strength_word[RDTPC_FLD_A_LO +: 2]);
      drive.ca_b   <= rdtpc_drive_e'(ca_drive_strength_word[RDTPC_FLD_B_LO +: 2]);
      // control group has no strong setting; code 2 still decodes to RDTPC_DRV_STRONG here
      drive.ctl_a  <= rdtpc_drive_e'(control_drive_strength_word[RDTPC_FLD_A_LO +: 2]);
      drive.ctl_b  <= rdtpc_drive_e'(control_drive_strength_word[RDTPC_FLD_B_LO +: 2]);
      drive.clk_13 <= rdtpc_drive_e'(clock_drive_strength_word[RDTPC_FLD_A_LO +: 2]);
      drive.clk_02 <= rdtpc_drive_e'(clock_drive_strength_word[RDTPC_FLD_B_LO +: 2]);
    end
  end

  // pre-launch select for the double-loaded nets
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ca_prelaunch <= 1'b0;
    end else begin
      ca_prelaunch <= timing_word[RDTPC_BIT_PRELAUNCH];
    end
  end

  assign term_code = extra_termination_word[2:0];
  // nonzero code ignores the mirror-mode bit under mirror
  assign mirror_kills = mirror_s &&
                        ((term_code != RDTPC_TERM_DEFER) ||
                         !extra_termination_word[RDTPC_BIT_MIRROR_ON]);
  assign pd_active = power_saving_word[RDTPC_BIT_PD_EN] && !cke0_s && !cke1_s;

  // termination value and enables
  always_comb begin
    unique case (term_code)
      RDTPC_TERM_200: next_term_value = RDTPC_TRM_200;
      RDTPC_TERM_300: next_term_value = RDTPC_TRM_300;
      RDTPC_TERM_OFF: next_term_value = RDTPC_TRM_OFF;
      // defer and reserved codes fall back on the base value
      default: next_term_value = timing_word[RDTPC_BIT_TERM_150] ? RDTPC_TRM_150
                                                                  : RDTPC_TRM_100;
    endcase
    next_term_main   = !mirror_kills;
    next_term_cs_odt = 1'b1;          // chip select and odt keep it under mirror
    if (term_code == RDTPC_TERM_OFF) begin
      next_term_main   = 1'b0;
      next_term_cs_odt = 1'b0;
    end
    // power-down type only matters when power-down is enabled
    if (pd_active && power_saving_word[RDTPC_BIT_PD_TYPE]) begin
      next_term_main   = 1'b0;
      next_term_cs_odt = 1'b0;
    end
  end

  // termination value register; 100 ohm until the words say otherwise
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      term_value <= RDTPC_TRM_100;
    end else begin
      term_value <= next_term_value;
    end
  end

  // termination enable for the inputs other than chip select and odt
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      term_on_main <= 1'b1;
    end else begin
      term_on_main <= next_term_main;
    end
  end

  // termination enable for chip select and odt; only code 111 or power-down with type bit set clear it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      term_on_cs_odt <= 1'b1;
    end else begin
      term_on_cs_odt <= next_term_cs_odt;
    end
  end

  // idle mode of the command/address outputs while deselected
  assign all_deselected = &cs_s;

  always_comb begin
    next_idle = RDTPC_IDLE_NORMAL;
    if (global_features_word[RDTPC_BIT_FLOAT_EN]) begin
      // bit 1 of the power word is reserved and never read
      next_idle = power_saving_word[RDTPC_BIT_WEAK_DRIVE] ? RDTPC_IDLE_WEAK
                                                          : RDTPC_IDLE_FLOAT;
    end
  end

  // ca_float/ca_weak only while every chip select is high; ca_idle_mode ignores the chip selects
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ca_idle_mode <= RDTPC_IDLE_NORMAL;
      ca_float     <= 1'b0;
      ca_weak      <= 1'b0;
    end else begin
      ca_idle_mode <= next_idle;
      ca_float     <= all_deselected && (next_idle == RDTPC_IDLE_FLOAT);
      ca_weak      <= all_deselected && (next_idle == RDTPC_IDLE_WEAK);
    end
  end

  // power-down state; entered on the edge after both clock enables read low with power bit 3 set
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      power_down <= 1'b0;
    end else begin
      power_down <= pd_active;
    end
  end

  // odt output; held low only in the termination-off power-down type
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      odt_out <= 1'b0;
    end else begin
      odt_out <= (pd_active && power_saving_word[RDTPC_BIT_PD_TYPE]) ? 1'b0
                                                                     : odt_s;
    end
  end

endmodule : rdtpc_ctrl

// >>> hdl/rdtpc_pkg.sv
// package for the drive, termination and power-saving control word decode
// assumes a single clock domain; words are written as 4-bit nibbles
package rdtpc_pkg;

  // control word indices on the 4-bit word-select field
  localparam logic [3:0] RDTPC_IDX_GLOBAL   = 4'h0;
  localparam logic [3:0] RDTPC_IDX_TIMING   = 4'h2;
  localparam logic [3:0] RDTPC_IDX_CA_DRV   = 4'h3;
  localparam logic [3:0] RDTPC_IDX_CTL_DRV  = 4'h4;
  localparam logic [3:0] RDTPC_IDX_CLK_DRV  = 4'h5;
  localparam logic [3:0] RDTPC_IDX_EXT_TERM = 4'h8;
  localparam logic [3:0] RDTPC_IDX_PWR_SAVE = 4'h9;

  // reset values of the words
  localparam logic [3:0] RDTPC_RST_WORD     = 4'h0;

  // field positions
  localparam int RDTPC_FLD_A_LO        = 0;
  localparam int RDTPC_FLD_B_LO        = 2;
  localparam int RDTPC_BIT_PRELAUNCH   = 0;
  localparam int RDTPC_BIT_FLOAT_EN    = 1;
  localparam int RDTPC_BIT_TERM_150    = 2;
  localparam int RDTPC_BIT_MIRROR_ON   = 3;
  localparam int RDTPC_BIT_WEAK_DRIVE  = 0;
  localparam int RDTPC_BIT_PD_TYPE     = 2;
  localparam int RDTPC_BIT_PD_EN       = 3;

  // termination value codes of the extra termination word
  localparam logic [2:0] RDTPC_TERM_DEFER   = 3'h0;
  localparam logic [2:0] RDTPC_TERM_200     = 3'h2;
  localparam logic [2:0] RDTPC_TERM_300     = 3'h4;
  localparam logic [2:0] RDTPC_TERM_OFF     = 3'h7;

  // drive strength encoding
  typedef enum logic [1:0] {
    RDTPC_DRV_LIGHT    = 2'h0,
    RDTPC_DRV_MODERATE = 2'h1,
    RDTPC_DRV_STRONG   = 2'h2,
    RDTPC_DRV_RSVD     = 2'h3
  } rdtpc_drive_e;

  // decoded termination selection
  typedef enum logic [2:0] {
    RDTPC_TRM_100,
    RDTPC_TRM_150,
    RDTPC_TRM_200,
    RDTPC_TRM_300,
    RDTPC_TRM_OFF
  } rdtpc_term_e;

  // idle behaviour of the command/address outputs
  typedef enum logic [1:0] {
    RDTPC_IDLE_NORMAL,
    RDTPC_IDLE_FLOAT,
    RDTPC_IDLE_WEAK
  } rdtpc_idle_e;

  // word write strobe with its data
  typedef struct packed {
    logic       valid;
    logic [3:0] index;
    logic [3:0] nibble;
  } rdtpc_write_s;

  // drive settings per group and side
  typedef struct packed {
    rdtpc_drive_e ca_a;
    rdtpc_drive_e ca_b;
    rdtpc_drive_e ctl_a;
    rdtpc_drive_e ctl_b;
    rdtpc_drive_e clk_13;
    rdtpc_drive_e clk_02;
  } rdtpc_drive_s;

endpackage : rdtpc_pkg

// >>> hdl/rdtpc_sync.sv
// two-flop synchroniser for a bus of pin levels
// assumes the inputs are asynchronous to clk
`timescale 1ns/1ns
module rdtpc_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] level
);

  logic [WIDTH-1:0] meta;

  initial begin
    if (WIDTH < 1) $error("rdtpc_sync: width must be at least one");
  end

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta  <= '0;
      level <= '0;
    end else begin
      meta  <= pin;
      level <= meta;
    end
  end

endmodule : rdtpc_sync

// >>> test/rdtpc_ctrl_props.sv
// checker for the control word decode: drive fields, termination, power-down
// assumes it is bound to rdtpc_ctrl and sees only that module's ports
`timescale 1ns/1ns
module rdtpc_ctrl_props
  import rdtpc_pkg::*;
#(
  parameter int NUM_CS = 4
) (
  input wire logic              clk,
  input wire logic              nrst,
  input wire rdtpc_write_s      word_write,
  input wire logic [NUM_CS-1:0] chip_select_in_n,
  input wire logic              clock_enable_in0,
  input wire logic              clock_enable_in1,
  input wire logic              odt_input_pin,
  input wire rdtpc_drive_s      drive,
  input wire rdtpc_term_e       term_value,
  input wire logic              term_on_main,
  input wire logic              term_on_cs_odt,
  input wire logic              ca_float,
  input wire logic              ca_weak,
  input wire logic              power_down,
  input wire logic              odt_out
);
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (!nrst);

  logic       wr;
  logic [3:0] idx;
  logic [3:0] nib;
  logic [1:0] up;

  // short names for the write strobe fields
  assign wr  = word_write.valid;
  assign idx = word_write.index;
  assign nib = word_write.nibble;

  // pin history only counts once the synchronisers have refilled after reset
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      up <= 2'h0;
    end else if (up != 2'h3) begin
      up <= up + 2'h1;
    end
  end

  ca_drive_a: assert property (wr && idx == RDTPC_IDX_CA_DRV |-> ##2
    drive.ca_a == $past(nib[1:0], 2) && drive.ca_b == $past(nib[3:2], 2))
    else $error("ca drive mismatch");
  ctl_drive_a: assert property (wr && idx == RDTPC_IDX_CTL_DRV |-> ##2
    drive.ctl_a == $past(nib[1:0], 2) && drive.ctl_b == $past(nib[3:2], 2))
    else $error("control drive mismatch");
  clk_drive_a: assert property (wr && idx == RDTPC_IDX_CLK_DRV |-> ##2
    drive.clk_13 == $past(nib[1:0], 2) && drive.clk_02 == $past(nib[3:2], 2))
    else $error("clock drive mismatch");
  term_off_a: assert property (wr && idx == RDTPC_IDX_EXT_TERM && nib[2:0] == 3'h7 |->
    ##2 !term_on_main && !term_on_cs_odt && term_value == RDTPC_TRM_OFF)
    else $error("termination not off");
  pd_gate_a: assert property (wr && idx == RDTPC_IDX_PWR_SAVE && !nib[3] |->
    ##2 !power_down)
    else $error("power-down while disabled");
  pd_entry_a: assert property (up == 2'h3 && power_down |->
    !$past(clock_enable_in0, 3) && !$past(clock_enable_in1, 3))
    else $error("power-down without both clock enables low");
  odt_follow_a: assert property (up == 2'h3 && !power_down |->
    odt_out == $past(odt_input_pin, 3))
    else $error("odt output not following its input");
  idle_cs_a: assert property (ca_float || ca_weak |->
    !(ca_float && ca_weak) && &$past(chip_select_in_n, 3))
    else $error("idle drive with a chip select low");

  // main scenarios reached
  cover property (power_down && !odt_out);
  cover property (ca_weak);
  cover property (term_on_cs_odt && !term_on_main);
endmodule : rdtpc_ctrl_props

bind rdtpc_ctrl rdtpc_ctrl_props #(.NUM_CS(NUM_CS)) rdtpc_ctrl_props_i (
  .clk, .nrst, .word_write, .chip_select_in_n, .clock_enable_in0,
  .clock_enable_in1, .odt_input_pin, .drive, .term_value, .term_on_main,
  .term_on_cs_odt, .ca_float, .ca_weak, .power_down, .odt_out
);

// >>> test/rdtpc_mc.sv
// memory controller model that writes the control words one nibble a strobe
// assumes clk is the device clock; changes land 2 ns after a rising edge
`timescale 1ns/1ns
module rdtpc_mc
  import rdtpc_pkg::*;
(
  input  wire logic    clk,
  output rdtpc_write_s word_write
);
  // idle at start
  initial begin
    word_write = '0;
  end

  // one-cycle strobe; any index is sent as given, undefined ones included
  task automatic wr(input logic [3:0] wi, input logic [3:0] wn);
    @(posedge clk);
    #2 word_write = {1'b1, wi, wn};
    @(posedge clk);
    // released fields carry the inverse so stale data is never mistaken
    #2 word_write = {1'b0, ~wi, ~wn};
  endtask : wr
endmodule : rdtpc_mc

// >>> test/rdtpc_ctrl_tb.sv
// self-checking bench for the control word decode
// assumes rdtpc_mc writes the words and the pins are driven from here
`timescale 1ns/1ns
module rdtpc_ctrl_tb;
  import rdtpc_pkg::*;
  logic         clk = 1'b0;
  logic         nrst = 1'b0;
  logic         mirror_in = 1'b0;
  logic [3:0]   chip_select_in_n = 4'he;
  logic         clock_enable_in0 = 1'b1;
  logic         clock_enable_in1 = 1'b1;
  logic         odt_input_pin = 1'b0;
  rdtpc_write_s word_write;
  rdtpc_drive_s drive;
  rdtpc_term_e  term_value;
  logic         term_on_main;
  logic         term_on_cs_odt;
  logic         ca_prelaunch;
  rdtpc_idle_e  ca_idle_mode;
  logic         ca_float;
  logic         ca_weak;
  logic         power_down;
  logic         odt_out;
  logic [4:0]   tsum;
  logic [3:0]   idl;
  logic [3:0]   pds;
  int           mismatches = 0;
  int           checks_done = 0;
  // drive rows: ca, control and clock nibbles, then the expected drive struct
  logic [23:0]  drv_tab [2] = '{24'h946619, 24'h219846};
  // term rows: mirror, extra word, then {term_value, main, cs_odt}
  logic [9:0]   trm_tab [8] = '{10'h04b, 10'h08f, 10'h0f0, 10'h205,
                                10'h307, 10'h349, 10'h3f0, 10'h007};

  // grouped outputs for compact compares
  assign tsum = {term_value, term_on_main, term_on_cs_odt};
  assign idl  = {ca_idle_mode, ca_float, ca_weak};
  assign pds  = {power_down, odt_out, term_on_main, term_on_cs_odt};

  always #25 clk = ~clk;

  rdtpc_mc rdtpc_mc_i (.clk, .word_write);
  rdtpc_ctrl #(.NUM_CS(4)) rdtpc_ctrl_i (
    .clk, .nrst, .word_write, .mirror_in, .chip_select_in_n, .clock_enable_in0,
    .clock_enable_in1, .odt_input_pin, .drive, .term_value, .term_on_main,
    .term_on_cs_odt, .ca_prelaunch, .ca_idle_mode, .ca_float, .ca_weak,
    .power_down, .odt_out
  );

  // step to 2 ns past the nth rising edge, clear of the sampling instant
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #2;
  endtask : tick

  task automatic chk(input string nm, input logic [16:0] ex, input logic [16:0] got);
    checks_done++;
    if (got !== ex) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk

  task automatic stop_test();
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  // main sequence
  initial begin
    tick(6);
    nrst = 1'b1;
    chk("reset state", 17'h3, {drive, tsum});
    chk("reset flags", 17'h0, 17'({power_down, odt_out, ca_prelaunch, idl}));
    for (int i = 0; i < 2; i++) begin
      rdtpc_mc_i.wr(RDTPC_IDX_CA_DRV, drv_tab[i][23:20]);
      rdtpc_mc_i.wr(RDTPC_IDX_CTL_DRV, drv_tab[i][19:16]);
      rdtpc_mc_i.wr(RDTPC_IDX_CLK_DRV, drv_tab[i][15:12]);
      rdtpc_mc_i.wr(4'h1, 4'hf);
      tick(2);
      chk("drive", 17'(drv_tab[i][11:0]), 17'(drive));
    end
    rdtpc_mc_i.wr(RDTPC_IDX_TIMING, 4'h5);
    tick(2);
    chk("prelaunch", 17'h1, 17'(ca_prelaunch));
    for (int i = 0; i < 8; i++) begin
      mirror_in = trm_tab[i][9];
      rdtpc_mc_i.wr(RDTPC_IDX_EXT_TERM, trm_tab[i][8:5]);
      tick(3);
      chk("termination", 17'(trm_tab[i][4:0]), 17'(tsum));
    end
    chip_select_in_n = 4'hf;
    rdtpc_mc_i.wr(RDTPC_IDX_PWR_SAVE, 4'h1);
    tick(3);
    chk("idle no float", 17'h0, 17'(idl));
    rdtpc_mc_i.wr(RDTPC_IDX_GLOBAL, 4'h2);
    tick(2);
    chk("idle weak", 17'h9, 17'(idl));
    rdtpc_mc_i.wr(RDTPC_IDX_PWR_SAVE, 4'h0);
    tick(2);
    chk("idle float", 17'h6, 17'(idl));
    chip_select_in_n = 4'hb;
    tick(3);
    chk("selected", 17'h4, 17'(idl));
    odt_input_pin = 1'b1;
    clock_enable_in0 = 1'b0;
    clock_enable_in1 = 1'b0;
    rdtpc_mc_i.wr(RDTPC_IDX_PWR_SAVE, 4'h4);
    tick(3);
    chk("pd disabled", 17'h7, 17'(pds));
    rdtpc_mc_i.wr(RDTPC_IDX_PWR_SAVE, 4'hc);
    tick(2);
    chk("pd odt low", 17'h8, 17'(pds));
    clock_enable_in0 = 1'b1;
    tick(3);
    chk("pd exit", 17'h7, 17'(pds));
    rdtpc_mc_i.wr(RDTPC_IDX_PWR_SAVE, 4'h8);
    clock_enable_in0 = 1'b0;
    tick(3);
    chk("pd odt follows", 17'hf, 17'(pds));
    // a second reset must clear the drive, timing and extra termination words back to their defaults
    nrst = 1'b0;
    tick(1);
    nrst = 1'b1;
    tick(3);
    chk("words cleared", 17'h3, {drive, tsum});
    stop_test();
  end

  // hang guard: 2000 cycles, far beyond the 107 cycles the sequence needs
  initial begin
    #100000;
    mismatches++;
    stop_test();
  end
endmodule : rdtpc_ctrl_tb
